// file: verilog/clkc_top.sv
// System clock select and PLL control with an AXI4-Lite register slave.
// Assumes stop_wake, power_control and irq_event come from logic on aclk;
// the fuse strap and the sub-oscillator clock arrive from outside and are synchronised.
`timescale 1ns/1ps
`default_nettype none
module clkc_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [clkc_pkg::CLKC_ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [clkc_pkg::CLKC_ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Power management inputs
  input wire logic crystal_input_fuse,
  input wire logic sub_osc_clk,
  input wire logic stop_wake,
  input wire logic [7:0] power_control,
  input wire logic irq_event,
  input wire logic low_power_state,
  // Clock generator controls
  output clkc_pkg::clkc_src_t sys_clk_src,
  output logic [3:0] rc_div_value,
  output logic rc_osc_run,
  output logic crystal_osc_run,
  output logic ring_osc_run,
  output logic stop_type_select_mode,
  // PLL controls
  output logic pll_run,
  output logic pll_out_is_pll,
  output logic [9:0] pll_fb_mult,
  output logic [3:0] pll_post_div,
  // Regulators and modes
  output logic main_regulator_on,
  output logic sub_regulator_on,
  output logic sub_active_mode
);
  import clkc_pkg::*;

  // Register state
  clkc_sys_t sys_reg;
  clkc_pll_t pll_reg;
  clkc_src_t src_applied_reg;
  logic [1:0] div_applied_reg;

  // AXI state
  logic aw_full_reg;
  logic [CLKC_ADDR_W-1:0] aw_addr_reg;
  logic w_full_reg;
  logic [7:0] w_byte_reg;
  logic w_lane0_reg;

  // Synchronised inputs, sub clock edge history and PLL gate output
  logic fuse_sync;
  logic sub_clk_sync;
  logic sub_clk_prev_reg;
  logic pll_on;

  // Fuse strap and sub-oscillator clock cross into aclk
  // Both are slow levels, so two flops are enough and no handshake is needed
  clkc_sync2 #(
    .WIDTH(2)
  ) clkc_sync2_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({crystal_input_fuse, sub_osc_clk}),
    .q({fuse_sync, sub_clk_sync})
  );

  // Rising edge of the synchronised sub clock marks one period
  // The sub clock is sampled as data, which keeps the block on one clock
  wire sub_tick = sub_clk_sync & ~sub_clk_prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_clk_prev_reg <= 1'b0;
    end else begin
      sub_clk_prev_reg <= sub_clk_sync;
    end
  end

  // PLL gate follows the enable bit with a delayed turn-off
  clkc_pll_gate clkc_pll_gate_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable_req(pll_reg.pll_enable_bit),
    .sub_tick(sub_tick),
    .pll_on(pll_on)
  );

  // Address decode shared by the write and read channels; zero when unmapped
  function automatic logic [1:0] clkc_decode(input logic [CLKC_ADDR_W-1:0] addr);
    if (addr == CLKC_ADDR_SYS) begin
      clkc_decode = 2'h1;
    end else if (addr == CLKC_ADDR_PLL) begin
      clkc_decode = 2'h2;
    end else begin
      clkc_decode = 2'h0;
    end
  endfunction

  // AXI handshakes and decode
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire [1:0] wr_hit = clkc_decode(aw_addr_reg);
  wire [1:0] rd_hit = clkc_decode(s_axi_araddr);
  wire wr_sys = wr_hit[0];
  wire wr_pll = wr_hit[1];
  wire wr_mapped = wr_sys | wr_pll;
  wire rd_sys = rd_hit[0];
  wire rd_pll = rd_hit[1];
  wire bvalid_next = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire aw_full_next = (aw_full_reg | aw_hs) & ~do_write;
  wire w_full_next = (w_full_reg | w_hs) & ~do_write;
  wire rvalid_next = ar_hs | (s_axi_rvalid & ~s_axi_rready);

  // Register write strobes need a mapped address and byte lane 0
  // A write with lane 0 off still answers OKAY but changes nothing
  wire sys_we = do_write & wr_sys & w_lane0_reg;
  wire pll_we = do_write & wr_pll & w_lane0_reg;
  clkc_sys_t sys_wdata;
  clkc_pll_t pll_wdata;
  assign sys_wdata = clkc_sys_t'(w_byte_reg);
  assign pll_wdata = clkc_pll_t'(w_byte_reg);

  // fuse low holds the crystal stop bit at one
  wire crystal_osc_stop_eff = sys_reg.crystal_osc_stop | ~fuse_sync;

  // status bit is the live routing of the PLL output
  wire pll_status = pll_on & pll_reg.pll_output_select;

  // Read view: status bit is hardware state, crystal stop shows the forced value
  clkc_sys_t sys_view;
  clkc_pll_t pll_view;
  always_comb begin
    sys_view = sys_reg;
    sys_view.crystal_osc_stop = crystal_osc_stop_eff;
    pll_view = pll_reg;
    pll_view.pll_output_status = pll_status;
  end
  wire [7:0] rd_byte = rd_sys ? sys_view : (rd_pll ? pll_view : 8'h00);

  // Address and data channels are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_byte_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      if (aw_hs) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_byte_reg <= s_axi_wdata[7:0];
        w_lane0_reg <= s_axi_wstrb[0];
      end
    end
  end

  // Ready flags stay low while a slot is held or a response waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CLKC_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_full_next & ~bvalid_next;
      s_axi_wready <= ~w_full_next & ~bvalid_next;
      s_axi_bvalid <= bvalid_next;
      if (do_write) begin
        s_axi_bresp <= wr_mapped ? CLKC_RESP_OKAY : CLKC_RESP_SLVERR;
      end
    end
  end

  // Read answers one cycle after the address is taken
  // Unmapped reads return zero with an error so software can spot a bad address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= CLKC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_hs) begin
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= (rd_sys | rd_pll) ? CLKC_RESP_OKAY : CLKC_RESP_SLVERR;
      end
    end
  end

  // both registers load their initial values on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reg <= clkc_sys_t'(CLKC_SYS_RESET);
    end else if (sys_we) begin
      // software rewrites the whole byte when clearing bypass
      sys_reg <= sys_wdata;
    end
  end

  // interrupt in sub-active or power-down sets output select; set wins
  wire pll_sel_set = irq_event & low_power_state;

  // PLL register; the status bit is never stored from a write
  // A same-cycle write cannot cancel an interrupt's request to select the PLL
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_reg <= clkc_pll_t'(CLKC_PLL_RESET);
    end else begin
      if (pll_we) begin
        pll_reg <= pll_wdata;
        pll_reg.pll_output_status <= 1'b0;
      end
      if (pll_sel_set) begin
        pll_reg.pll_output_select <= 1'b1;
      end
    end
  end

  // with bypass set the written source and divide apply at once
  // with bypass clear they wait for stop-mode wake-up
  // Limitation: without bypass only the value stored at wake-up is applied
  wire apply_now = sys_reg.clock_switch_bypass | stop_wake;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_applied_reg <= CLKC_SRC_RC;
      div_applied_reg <= 2'h0;
    end else if (apply_now) begin
      // source code picks RC, crystal, sub/PLL or ring
      src_applied_reg <= sys_reg.clk_src;
      // divide changes by software rely on bypass being set, in the same write or earlier
      div_applied_reg <= sys_reg.rc_div;
    end
  end

  // Derived oscillator and mode controls
  wire on_rc = src_applied_reg == CLKC_SRC_RC;
  wire on_xtal = src_applied_reg == CLKC_SRC_XTAL;
  wire on_sub = src_applied_reg == CLKC_SRC_SUB;
  // RC stop honoured only with bypass; a selected RC never stops
  wire rc_run_next = on_rc | ~(sys_reg.clock_switch_bypass & sys_reg.rc_osc_stop);
  // crystal stop honoured only with bypass, else runs when selected
  wire xtal_en = sys_reg.clock_switch_bypass ? ~crystal_osc_stop_eff : on_xtal;
  wire xtal_run_next = fuse_sync & xtal_en;
  // stop type only counts when power control is the stop code
  wire stop_type_select_next = sys_reg.stop_type_select & (power_control == CLKC_POWER_CONTROL_STOP);
  // sub/PLL source, bypass output and PLL off means sub-active
  wire sub_active_next = on_sub & ~pll_reg.pll_output_select & ~pll_on;
  // with bypass output, regulator select picks main or sub
  // Outside sub-active the regulator bit decides even with the PLL off
  wire main_reg_next = pll_reg.pll_output_select
                       | (pll_reg.regulator_select & ~sub_active_next);

  // divide is issued only while RC drives the system clock
  wire [3:0] rc_div_next = on_rc ? clkc_pow2(div_applied_reg) : clkc_pow2(2'h0);

  // Outputs are all registered; the clock generator sees no decode glitches
  // Reset values are the state the clock generator comes up in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_clk_src <= CLKC_SRC_RC;
      rc_div_value <= clkc_pow2(2'h0);
      rc_osc_run <= 1'b1;
      crystal_osc_run <= 1'b0;
      stop_type_select_mode <= 1'b0;
      sub_active_mode <= 1'b0;
      main_regulator_on <= 1'b1;
      sub_regulator_on <= 1'b0;
    end else begin
      sys_clk_src <= src_applied_reg;
      rc_div_value <= rc_div_next;
      rc_osc_run <= rc_run_next;
      crystal_osc_run <= xtal_run_next;
      stop_type_select_mode <= stop_type_select_next;
      sub_active_mode <= sub_active_next;
      main_regulator_on <= main_reg_next;
      sub_regulator_on <= ~main_reg_next;
    end
  end

  // ring oscillator for timers and debounce never depends on the source
  // Held in a flop only so that every output comes from a register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ring_osc_run <= 1'b1;
    end else begin
      ring_osc_run <= 1'b1;
    end
  end

  // PLL outputs
  // Codes are turned into plain ratios here, once, for the PLL to use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_run <= 1'b0;
      pll_out_is_pll <= 1'b0;
      pll_fb_mult <= clkc_fb_mult(2'h0);
      pll_post_div <= clkc_pow2(2'h0);
    end else begin
      // oscillator stays up while bypassed, as long as enabled
      pll_run <= pll_on;
      // output select routes multiplied clock only when enabled
      pll_out_is_pll <= pll_status;
      // output is input times multiplier over post divider
      pll_fb_mult <= clkc_fb_mult(pll_reg.pll_feedback_field);
      pll_post_div <= clkc_pow2(pll_reg.pll_post_divider_field);
    end
  end
endmodule
`default_nettype wire

// file: verilog/clkc_pkg.sv
// Constants, field layouts and helpers for the system clock select and PLL control block.
// Assumes one 200 MHz bus clock and AXI4-Lite access from software.
// Overview of operation
// - reset runs RC oscillator, divide by one
// - ring oscillator always clocks timers, debounce
// - RC divide 1/2/4/8, only on RC
// - bypass zero defers source change to wake
// - bypass one applies source change immediately
// - RC stop bit honoured only with bypass
// - crystal stop bit honoured only with bypass
// - fuse zero forces crystal stop to one
// - source codes RC, crystal, sub/PLL, ring
// - stop type applies only at power 0x03
// - PLL status reads bypass zero, PLL one
// - output select chooses bypass or PLL clock
// - PLL oscillator keeps running while bypassed
// - interrupt in sub-active sets output select
// - regulator select chooses sub or main; output select at PLL forces main
// - feedback multiplier 616, 512, 450, 338
// - post divider 1, 2, 4, 8
// - PLL disable takes two sub-oscillator periods
// - output equals input times feedback over divider
// - sub-active mode enables sub regulator automatically
package clkc_pkg;
  // Printed offsets are register indices; byte address is four times that
  localparam logic [7:0] CLKC_IDX_SYS = 8'h8A;
  localparam logic [7:0] CLKC_IDX_PLL = 8'hA7;
  localparam logic [11:0] CLKC_ADDR_SYS = {2'h0, CLKC_IDX_SYS, 2'h0};
  localparam logic [11:0] CLKC_ADDR_PLL = {2'h0, CLKC_IDX_PLL, 2'h0};
  localparam int CLKC_ADDR_W = 12;
  localparam logic [7:0] CLKC_SYS_RESET = 8'h04;
  localparam logic [7:0] CLKC_PLL_RESET = 8'h00;
  localparam logic [7:0] CLKC_POWER_CONTROL_STOP = 8'h03;
  localparam logic [1:0] CLKC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CLKC_RESP_SLVERR = 2'h2;
  localparam logic [1:0] CLKC_PLL_OFF_TICKS = 2'h2;

  // Clock source codes
  typedef enum logic [1:0] {
    CLKC_SRC_RC = 2'b00,
    CLKC_SRC_XTAL = 2'b01,
    CLKC_SRC_SUB = 2'b10,
    CLKC_SRC_RING = 2'b11
  } clkc_src_t;

  // System clock control layout, bit 7 down to bit 0
  typedef struct packed {
    logic stop_type_select;
    logic [1:0] rc_div;
    logic clock_switch_bypass;
    logic rc_osc_stop;
    logic crystal_osc_stop;
    clkc_src_t clk_src;
  } clkc_sys_t;

  // PLL control layout, bit 7 down to bit 0
  typedef struct packed {
    logic pll_output_status;
    logic pll_output_select;
    logic regulator_select;
    logic [1:0] pll_feedback_field;
    logic [1:0] pll_post_divider_field;
    logic pll_enable_bit;
  } clkc_pll_t;

  // Feedback multiplier from its code
  function automatic logic [9:0] clkc_fb_mult(input logic [1:0] code);
    case (code)
      2'h0: clkc_fb_mult = 10'h268;
      2'h1: clkc_fb_mult = 10'h200;
      2'h2: clkc_fb_mult = 10'h1C2;
      default: clkc_fb_mult = 10'h152;
    endcase
  endfunction

  // Power-of-two divide value (1, 2, 4, 8) from a two-bit code
  function automatic logic [3:0] clkc_pow2(input logic [1:0] code);
    clkc_pow2 = 4'h1 << code;
  endfunction
endpackage

// file: verilog/clkc_sync2.sv
// Two-flop synchroniser for levels arriving from outside the bus clock domain.
// Assumes the input is a slow level; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module clkc_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // Two stages, reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: verilog/clkc_pll_gate.sv
// PLL enable gate: turns on at once, turns off after a count of sub-oscillator ticks.
// Assumes sub_tick is a one-cycle pulse per sub-oscillator period.
`timescale 1ns/1ps
`default_nettype none
module clkc_pll_gate
  import clkc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic enable_req,
  input wire logic sub_tick,
  output logic pll_on
);
  logic [1:0] cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 2'h0;
      pll_on <= 1'b0;
    end else if (enable_req) begin
      cnt_reg <= 2'h0;
      pll_on <= 1'b1;
    end else if (pll_on && sub_tick) begin
      cnt_reg <= cnt_reg + 2'h1;
      if (cnt_reg + 2'h1 == CLKC_PLL_OFF_TICKS) begin
        pll_on <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: test/clkc_asserts.sv
// Concurrent checks on the ports of the clock select and PLL control block.
// Assumes it is bound to clkc_top and that everything runs on aclk.
`timescale 1ns/1ps
`default_nettype none
module clkc_asserts
  import clkc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Clock and PLL controls
  input wire clkc_pkg::clkc_src_t sys_clk_src,
  input wire logic [3:0] rc_div_value,
  input wire logic ring_osc_run,
  input wire logic pll_run,
  input wire logic pll_out_is_pll,
  input wire logic [9:0] pll_fb_mult,
  input wire logic [3:0] pll_post_div,
  input wire logic main_regulator_on,
  input wire logic sub_regulator_on,
  input wire logic sub_active_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ring; ring_osc_run; endproperty
  a_ring: assert property (p_ring) else $error("ring oscillator stopped");
  property p_div; sys_clk_src != CLKC_SRC_RC |-> rc_div_value == 4'h1; endproperty
  a_div: assert property (p_div) else $error("divider active off RC");
  property p_fb; pll_fb_mult inside {10'h268, 10'h200, 10'h1C2, 10'h152}; endproperty
  a_fb: assert property (p_fb) else $error("bad feedback multiplier");
  property p_pd; pll_post_div inside {4'h1, 4'h2, 4'h4, 4'h8}; endproperty
  a_pd: assert property (p_pd) else $error("bad post divider");
  property p_reg; sub_regulator_on != main_regulator_on; endproperty
  a_reg: assert property (p_reg) else $error("regulator choice not exclusive");
  property p_stat; pll_out_is_pll |-> pll_run; endproperty
  a_stat: assert property (p_stat) else $error("status shows PLL while off");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdrop: assert property (p_rdrop) else $error("read data not released");
  property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bdrop: assert property (p_bdrop) else $error("write response not released");
  property p_subact; sub_active_mode |-> sub_regulator_on && !main_regulator_on; endproperty
  a_subact: assert property (p_subact) else $error("sub-active without sub regulator");

  // Main scenarios reached
  c_err: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == CLKC_RESP_SLVERR);
  c_pll: cover property (pll_out_is_pll);
  c_ring: cover property (sys_clk_src == CLKC_SRC_RING);
  c_sub: cover property (sub_active_mode);
endmodule
`default_nettype wire

// file: test/test_system_clock_select_pll_ctrl.sv
// Self-checking bench for the clock select and PLL control block.
// Assumes clkc_top with AXI4-Lite access; the bench acts as bus master.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module test_system_clock_select_pll_ctrl;
  import clkc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdata_q;
  logic [3:0] s_axi_wstrb, rc_div_value, pll_post_div;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_q, rresp_q;
  logic crystal_input_fuse, sub_osc_clk, stop_wake, irq_event, low_power_state;
  logic [7:0] power_control, d;
  clkc_src_t sys_clk_src;
  logic rc_osc_run, crystal_osc_run, ring_osc_run, stop_type_select_mode, pll_run, pll_out_is_pll;
  logic [9:0] pll_fb_mult;
  logic main_regulator_on, sub_regulator_on, sub_active_mode;
  logic [31:0] seed;
  int n_fail, compares;

  clkc_top clkc_top_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .crystal_input_fuse, .sub_osc_clk, .stop_wake, .power_control,
    .irq_event, .low_power_state, .sys_clk_src, .rc_div_value, .rc_osc_run, .crystal_osc_run,
    .ring_osc_run, .stop_type_select_mode, .pll_run, .pll_out_is_pll, .pll_fb_mult, .pll_post_div,
    .main_regulator_on, .sub_regulator_on, .sub_active_mode);

  // 200 MHz bus clock and a slow sub oscillator, unrelated in phase
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    sub_osc_clk = 1'h0;
    forever #103 sub_osc_clk = ~sub_osc_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [9:0] fbm(input logic [1:0] c);
    case (c)
      2'h0: fbm = 10'h268;
      2'h1: fbm = 10'h200;
      2'h2: fbm = 10'h1C2;
      default: fbm = 10'h152;
    endcase
  endfunction

  // Handshakes are judged at the falling edge, where the next rising edge's view is settled
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready;
      bresp_q = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
    end while (!tb);
  endtask
  task automatic rd(input logic [11:0] a);
    logic ta, t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      t = s_axi_rvalid & s_axi_rready;
      rdata_q = s_axi_rdata;
      rresp_q = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (t) s_axi_rready <= 1'h0;
    end while (!t);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the run needs about 2500 cycles
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    {stop_wake, irq_event, low_power_state} = 3'h0;
    crystal_input_fuse = 1'h1;
    power_control = 8'h03;
    seed = 32'h222C5109;
    n_fail = 0;
    compares = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    rd(CLKC_ADDR_SYS);
    `CHK(rdata_q, 32'h04)
    rd(CLKC_ADDR_PLL);
    `CHK(rdata_q, 32'h00)
    `CHK(sys_clk_src, CLKC_SRC_RC)
    `CHK(rc_div_value, 4'h1)
    // Source change without bypass waits for wake-up
    wr(CLKC_ADDR_SYS, 8'h01);
    repeat (4) @(posedge aclk);
    `CHK(sys_clk_src, CLKC_SRC_RC)
    stop_wake <= 1'h1;
    @(posedge aclk);
    stop_wake <= 1'h0;
    repeat (3) @(posedge aclk);
    `CHK(sys_clk_src, CLKC_SRC_XTAL)
    // Every source and divider code under bypass, random stop bits
    // bypass set in the same write
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      d = {seed[0], i[3:2], 1'h1, seed[1], seed[2] & (i[1:0] != 2'h1), i[1:0]};
      wr(CLKC_ADDR_SYS, d);
      repeat (3) @(posedge aclk);
      `CHK(sys_clk_src, d[1:0])
      `CHK(rc_div_value, (d[1:0] == 2'h0) ? 4'h1 << d[6:5] : 4'h1)
      `CHK(rc_osc_run, !(d[3] && d[1:0] != 2'h0))
      `CHK(crystal_osc_run, !d[2])
      `CHK(stop_type_select_mode, d[7])
      rd(CLKC_ADDR_SYS);
      `CHK(rdata_q, {24'h0, d})
    end
    // stop type only at stop code
    power_control <= 8'h00;
    wr(CLKC_ADDR_PLL, 8'h20);
    wr(CLKC_ADDR_SYS, 8'h90);
    repeat (3) @(posedge aclk);
    `CHK(stop_type_select_mode, 1'h0)
    `CHK(main_regulator_on, 1'h1)
    power_control <= 8'h03;
    s_axi_wstrb <= 4'hE;
    repeat (2) @(posedge aclk);
    `CHK(stop_type_select_mode, 1'h1)
    // Lane 0 off: answered, nothing written
    wr(CLKC_ADDR_SYS, 8'h11);
    `CHK(bresp_q, CLKC_RESP_OKAY)
    rd(CLKC_ADDR_SYS);
    `CHK(rdata_q, 32'h90)
    s_axi_wstrb <= 4'hF;
    // Fuse low pins the crystal off
    crystal_input_fuse <= 1'h0;
    repeat (4) @(posedge aclk);
    wr(CLKC_ADDR_SYS, 8'h10);
    repeat (3) @(posedge aclk);
    `CHK(crystal_osc_run, 1'h0)
    rd(CLKC_ADDR_SYS);
    `CHK(rdata_q, 32'h14)
    crystal_input_fuse <= 1'h1;
    // Clearing bypass keeps the rest; source stays sub/PLL
    wr(CLKC_ADDR_SYS, 8'h12);
    wr(CLKC_ADDR_SYS, 8'h02);
    `CHK(bresp_q, CLKC_RESP_OKAY)
    rd(CLKC_ADDR_SYS);
    `CHK(rdata_q, 32'h02)
    // PLL fields at random, every code of both dividers
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      d = {seed[7:5], i[1:0], i[3:2], seed[0]};
      wr(CLKC_ADDR_PLL, d);
      repeat (120) @(posedge aclk);
      `CHK(pll_fb_mult, fbm(d[4:3]))
      `CHK(pll_post_div, 4'h1 << d[2:1])
      `CHK(pll_run, d[0])
      `CHK(pll_out_is_pll, d[0] & d[6])
      `CHK(sub_active_mode, !d[6] && !d[0])
      `CHK(main_regulator_on, d[6] | (d[0] & d[5]))
      `CHK(sub_regulator_on, !(d[6] | (d[0] & d[5])))
      rd(CLKC_ADDR_PLL);
      `CHK(rdata_q, {24'h0, d[0] & d[6], d[6:0]})
    end
    // Disable takes sub oscillator periods, not bus cycles
    wr(CLKC_ADDR_PLL, 8'h01);
    repeat (120) @(posedge aclk);
    wr(CLKC_ADDR_PLL, 8'h00);
    repeat (2) @(posedge aclk);
    `CHK(pll_run, 1'h1)
    wr(CLKC_ADDR_PLL, 8'h01);
    repeat (120) @(posedge aclk);
    // Interrupt in low power selects the PLL output
    low_power_state <= 1'h1;
    irq_event <= 1'h1;
    @(posedge aclk);
    irq_event <= 1'h0;
    repeat (3) @(posedge aclk);
    `CHK(pll_out_is_pll, 1'h1)
    low_power_state <= 1'h0;
    // Unmapped addresses are refused
    rd(12'h000);
    `CHK(rresp_q, CLKC_RESP_SLVERR)
    `CHK(rdata_q, 32'h0)
    wr(12'h004, 8'hFF);
    `CHK(bresp_q, CLKC_RESP_SLVERR)
    print_verdict();
  end
endmodule
bind clkc_top clkc_asserts clkc_asserts_inst (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .sys_clk_src,
  .rc_div_value, .ring_osc_run, .pll_run, .pll_out_is_pll, .pll_fb_mult, .pll_post_div,
  .main_regulator_on, .sub_regulator_on, .sub_active_mode);
`default_nettype wire
